// *** dv/ipc_host_model.sv ***
// host processor model: register port master and pin pull-ups
// assumes the controller takes requests on rising clk_i
`timescale 1ns/100ps
module ipc_host_model (
  input wire clk_i,
  output reg [7:0] reg_addr_o,
  output reg [7:0] reg_wdata_o,
  output reg reg_wr_o,
  output reg reg_rd_o,
  input wire [7:0] reg_rdata_i,
  input wire [2:0] pin_i,
  input wire [2:0] pin_oe_n_i,
  output wire [2:0] pin_level_o
);
  // released pins float up through the board pull-up
  assign pin_level_o = pin_oe_n_i | pin_i;
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // one-cycle write strobe; clear bits need no second write
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_i);
      #2;
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(posedge clk_i);
      #2;
      reg_wr_o = 1'b0;
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge clk_i);
      #2;
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(posedge clk_i);
      #2;
      reg_rd_o = 1'b0;
      reg_addr_o = ~a;
      d = reg_rdata_i;
    end
  endtask
endmodule

// *** dv/ipc_interrupt_pin_controller_tb.sv ***
// testbench for the interrupt pin controller
// assumes the host model drives the register port
`timescale 1ns/100ps
module ipc_interrupt_pin_controller_tb;
  reg clk_i, sys_rst_i, cp_locked_i, cp_free_run_en_i, mute_request_i;
  reg sd_core_irq_i, cec_irq_i, receiver_irq_i;
  wire [7:0] addr, wdata, rdata;
  wire wr, rd;
  wire [2:0] pin, oe_n, lvl;
  integer mismatches = 0, total_checks = 0, cycles = 0, i, n;
  ipc_interrupt_pin_controller u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .cp_locked_i(cp_locked_i), .cp_free_run_en_i(cp_free_run_en_i),
    .mute_request_i(mute_request_i), .sd_core_irq_i(sd_core_irq_i), .cec_irq_i(cec_irq_i),
    .receiver_irq_i(receiver_irq_i), .irq_pin_a_o(pin[0]), .irq_pin_a_oe_n_o(oe_n[0]),
    .irq_pin_b_o(pin[1]), .irq_pin_b_oe_n_o(oe_n[1]), .irq_pin_c_o(pin[2]),
    .irq_pin_c_oe_n_o(oe_n[2]));
  ipc_host_model u_host (.clk_i(clk_i), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata), .pin_i(pin), .pin_oe_n_i(oe_n),
    .pin_level_o(lvl));
  ////////////////////////////////////////
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task rc(input [7:0] a, input [7:0] e);
    reg [7:0] d;
    begin
      u_host.rd(a, d);
      chk($sformatf("reg %h", a), d, e);
    end
  endtask
  task pins(input [2:0] e);
    begin
      chk("pin levels", {5'h00, lvl}, {5'h00, e});
    end
  endtask
  task ev(input lk, input [7:0] e);
    begin
      cp_locked_i = lk;
      repeat (2) @(posedge clk_i);
      rc(8'h44, e);
      u_host.wr(8'h45, 8'h1f);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      conclude;
    end
  end
  ////////////////////////////////////////
  initial begin
    {sys_rst_i, cp_locked_i, cp_free_run_en_i, mute_request_i} = 4'h8;
    {sd_core_irq_i, cec_irq_i, receiver_irq_i} = 3'h0;
    repeat (4) @(posedge clk_i);
    #2 sys_rst_i = 1'b0;
    rc(8'h1d, 8'h78);
    rc(8'h41, 8'h20);
    rc(8'h44, 8'h00);
    u_host.wr(8'h43, 8'hff);
    rc(8'h43, 8'h00);
    rc(8'h50, 8'h00);
    u_host.wr(8'h1d, 8'h18);
    u_host.wr(8'h40, 8'h03);
    rc(8'h40, 8'h03);
    pins(3'b111);
    $display("test reset done");
    u_host.wr(8'h47, 8'h01);
    u_host.wr(8'h48, 8'h01);
    for (i = 0; i < 4; i = i + 1) begin
      u_host.wr(8'h40, {i[1:0], 6'h02});
      sd_core_irq_i = 1'b1;
      repeat (3) @(posedge clk_i);
      #1 pins(3'b011);
      n = 0;
      while (lvl[0] === 1'b1 && n < 100) begin
        @(posedge clk_i);
        #1 n = n + 1;
      end
      chk("pulse", n[7:0], i == 0 ? 8'd4 : i == 1 ? 8'd16 : i == 2 ? 8'd64 : 8'd100);
      rc(8'h43, 8'h01);
      rc(8'h3f, 8'h05);
      u_host.wr(8'h45, 8'h01);
      sd_core_irq_i = 1'b0;
      rc(8'h3f, 8'h00);
      pins(3'b110);
    end
    $display("test pulse done");
    u_host.wr(8'h47, 8'h00);
    u_host.wr(8'h40, 8'h06);
    rc(8'h43, 8'h02);
    rc(8'h44, 8'h00);
    u_host.wr(8'h40, 8'h02);
    u_host.wr(8'h47, 8'h02);
    u_host.wr(8'h40, 8'h06);
    u_host.wr(8'h45, 8'h00);
    rc(8'h44, 8'h02);
    u_host.wr(8'h45, 8'h02);
    rc(8'h44, 8'h00);
    u_host.wr(8'h40, 8'h02);
    $display("test stimulus done");
    cp_free_run_en_i = 1'b1;
    u_host.wr(8'h47, 8'h18);
    u_host.wr(8'h41, 8'h00);
    ev(1'b1, 8'h10);
    rc(8'h43, 8'h10);
    ev(1'b0, 8'h08);
    u_host.wr(8'h41, 8'h20);
    ev(1'b1, 8'h18);
    cp_free_run_en_i = 1'b0;
    ev(1'b0, 8'h00);
    $display("test lock done");
    u_host.wr(8'h47, 8'h00);
    u_host.wr(8'h40, 8'h22);
    mute_request_i = 1'b1;
    rc(8'h43, 8'h04);
    rc(8'h44, 8'h04);
    pins(3'b110);
    u_host.wr(8'h45, 8'h04);
    mute_request_i = 1'b0;
    $display("test keep done");
    {cec_irq_i, receiver_irq_i} = 2'b11;
    u_host.wr(8'h47, 8'h01);
    u_host.wr(8'h46, 8'h01);
    u_host.wr(8'h41, 8'h21);
    u_host.wr(8'h40, 8'h12);
    sd_core_irq_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1 pins(3'b011);
    rc(8'h3f, 8'h37);
    sd_core_irq_i = 1'b0;
    repeat (3) @(posedge clk_i);
    #1 pins(3'b010);
    u_host.wr(8'h45, 8'h01);
    u_host.wr(8'h41, 8'h29);
    sd_core_irq_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1 pins(3'b001);
    $display("test raw and pin b done");
    u_host.wr(8'h41, 8'h39);
    u_host.wr(8'h40, 8'h11);
    repeat (2) @(posedge clk_i);
    #1 pins(3'b000);
    sd_core_irq_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 pins(3'b011);
    u_host.wr(8'h1d, 8'he0);
    repeat (2) @(posedge clk_i);
    #1 pins(3'b111);
    rc(8'h45, 8'h00);
    $display("test pad done");
    conclude;
  end
endmodule

// *** dv/ipc_props.sv ***
// port checker for the interrupt pin controller
// assumes one crystal clock and an active-high async reset
`timescale 1ns/100ps
module ipc_props (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire irq_pin_a_o,
  input wire irq_pin_a_oe_n_o,
  input wire irq_pin_b_oe_n_o,
  input wire irq_pin_c_o,
  input wire irq_pin_c_oe_n_o
);
  reg [7:0] cfg_a;
  reg [7:0] cfg_b;
  reg [7:0] pad;
  reg [6:0] run;
  // shadow of config writes, length of the current pin a pulse
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_a <= 8'h00;
      cfg_b <= 8'h20;
      pad <= 8'h78;
      run <= 7'h00;
    end else begin
      if (reg_wr_i && reg_addr_i == 8'h40) cfg_a <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == 8'h41) cfg_b <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == 8'h1d) pad <= reg_wdata_i;
      run <= irq_pin_a_o ? run + 7'h01 : 7'h00;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  pad_a_off_a: assert property ($past(pad[7]) |-> irq_pin_a_oe_n_o)
    else $error("pin a driven with pad off");
  pad_c_off_a: assert property ($past(pad[5]) |-> irq_pin_c_oe_n_o)
    else $error("pin c driven with pad off");
  style_off_a: assert property ($past(cfg_a[1:0] == 2'h3) |-> irq_pin_a_oe_n_o)
    else $error("pin a driven in off style");
  style_driven_a: assert property (
    $past(!pad[7] && (cfg_a[1:0] == 2'h1 || cfg_a[1:0] == 2'h2)) |-> !irq_pin_a_oe_n_o)
    else $error("pin a released in driven style");
  pin_b_off_a: assert property (
    $past(!cfg_b[3] && cfg_b[1:0] == 2'h0) |-> irq_pin_b_oe_n_o)
    else $error("disabled pin b driven");
  pin_c_drain_a: assert property (!irq_pin_c_oe_n_o |-> !irq_pin_c_o)
    else $error("pin c driven high");
  pulse_len_a: assert property ($fell(irq_pin_a_o) && !pad[7] && cfg_a[1:0] == 2'h2
    && cfg_a[7:6] != 2'h3 && !cfg_a[4] |-> run == (cfg_a[7:6] == 2'h0 ? 7'h04 :
    cfg_a[7:6] == 2'h1 ? 7'h10 : 7'h40))
    else $error("pin a pulse length wrong");
  clear_zero_a: assert property (reg_rd_i && reg_addr_i == 8'h45 |=> reg_rdata_o == 8'h00)
    else $error("clear register read not zero");
endmodule
bind ipc_interrupt_pin_controller ipc_props u_props (.clk_i, .sys_rst_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_pin_a_o, .irq_pin_a_oe_n_o,
  .irq_pin_b_oe_n_o, .irq_pin_c_o, .irq_pin_c_oe_n_o);

// *** verilog/ipc_interrupt_pin_controller.v ***
// interrupt aggregation and pin signalling: raw event bits, sticky
// status, per-pin masks for three pins, pulse timing and drive style for pins a and b.
// assumes clk_i is the crystal clock and that all event inputs and the
// register port come from logic on that same clock.
//
// Notes on behaviour
// - pins a, b pulse 4/16/64 periods or hold
// - style: open drain, low, high, disabled
// - pin state bit set until masked flags cleared
// - keep control latches mute flag without mask
// - raw-out control drives pin from raw signal
// - manual stimulus makes event, reaches pin if masked
// - pin b inactive unless its enable is set
// - edge mode: lock on rising, unlock on falling, or both on both edges
// - lock raw on lock, only in free run
// - unlock raw while unlocked, only in free run
// - mute raw follows receiver mute request
// - stimulus raw shows stimulus control directly
// - sd core raw follows sd processor interrupt
// - mute flag sticky until its clear written
// - lock, unlock flags set on interrupting transition
// - flag valid only when some pin masks it, or mute flag with keep set
// - summary bits report cec and receiver interrupts
// - pad power-down disables its pin pad
// - write one clears flag, zero no effect
// - per-pin mask bits enable each source
`timescale 1ns/100ps
`include "ipc_regs.vh"

module ipc_interrupt_pin_controller (
  input wire clk_i,
  input wire sys_rst_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  input wire cp_locked_i,
  input wire cp_free_run_en_i,
  input wire mute_request_i,
  input wire sd_core_irq_i,
  input wire cec_irq_i,
  input wire receiver_irq_i,
  output reg irq_pin_a_o,
  output reg irq_pin_a_oe_n_o,
  output reg irq_pin_b_o,
  output reg irq_pin_b_oe_n_o,
  output reg irq_pin_c_o,
  output reg irq_pin_c_oe_n_o
);

  localparam NS = `IPC_NUM_SRC;

  ////////////////////////////////////////////////////////////////////////
  // functions

  function [6:0] pulse_periods;
    input [1:0] code;
    begin
      case (code)
        `IPC_LEN_SHORT: pulse_periods = `IPC_PERIODS_SHORT;
        `IPC_LEN_MID: pulse_periods = `IPC_PERIODS_MID;
        `IPC_LEN_LONG: pulse_periods = `IPC_PERIODS_LONG;
        default: pulse_periods = 7'h00;
      endcase
    end
  endfunction

  // returns {out, oe_n}; oe_n low while the pin is driven
  function [1:0] pin_drive;
    input [1:0] style;
    input active;
    input powered_down;
    begin
      if (powered_down) begin
        pin_drive = 2'h1;
      end else begin
        case (style)
          `IPC_STYLE_OPEN_DRAIN: pin_drive = {1'b0, ~active};
          `IPC_STYLE_ACTIVE_LOW: pin_drive = {~active, 1'b0};
          `IPC_STYLE_ACTIVE_HIGH: pin_drive = {active, 1'b0};
          default: pin_drive = 2'h1;
        endcase
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers

  reg [7:0] pad_ctrl;
  reg [7:0] pin_a_cfg;
  reg [7:0] pin_b_cfg;
  reg [NS-1:0] mask_a;
  reg [NS-1:0] mask_b;
  reg [NS-1:0] mask_c;
  reg [NS-1:0] latched;
  reg [NS-1:0] raw_prev;
  reg cp_locked_prev;
  reg cec_summary_flag;
  reg receiver_summary_flag;

  wire [1:0] pin_a_pulse_len = pin_a_cfg[`IPC_CFG_LEN_HI:`IPC_CFG_LEN_LO];
  wire [1:0] pin_b_pulse_len = pin_b_cfg[`IPC_CFG_LEN_HI:`IPC_CFG_LEN_LO];
  wire [1:0] pin_a_drive_style = pin_a_cfg[`IPC_CFG_STYLE_HI:`IPC_CFG_STYLE_LO];
  wire [1:0] pin_b_drive_style = pin_b_cfg[`IPC_CFG_STYLE_HI:`IPC_CFG_STYLE_LO];
  wire keep_masked_flags = pin_a_cfg[`IPC_CFG_KEEP];
  wire pin_a_raw_out = pin_a_cfg[`IPC_CFG_RAW_OUT];
  wire manual_stimulus = pin_a_cfg[`IPC_CFG_STIM];
  wire lock_edge_mode = pin_b_cfg[`IPC_CFG_EDGE];
  wire pin_b_raw_out = pin_b_cfg[`IPC_CFG_RAW_OUT];
  wire pin_b_enable = pin_b_cfg[`IPC_CFG_PIN_B_EN];

  ////////////////////////////////////////////////////////////////////////
  // raw bits and events

  wire cp_rise = cp_free_run_en_i & cp_locked_i & ~cp_locked_prev;
  wire cp_fall = cp_free_run_en_i & ~cp_locked_i & cp_locked_prev;
  wire cp_change = cp_rise | cp_fall;

  wire [NS-1:0] raw_bits;
  assign raw_bits[`IPC_SRC_LOCK] = cp_free_run_en_i & cp_locked_i;
  assign raw_bits[`IPC_SRC_UNLOCK] = cp_free_run_en_i & ~cp_locked_i;
  assign raw_bits[`IPC_SRC_MUTE] = mute_request_i;
  assign raw_bits[`IPC_SRC_STIM] = manual_stimulus;
  assign raw_bits[`IPC_SRC_SD] = sd_core_irq_i;

  wire [NS-1:0] events;
  assign events[`IPC_SRC_LOCK] = lock_edge_mode ? cp_change : cp_rise;
  assign events[`IPC_SRC_UNLOCK] = lock_edge_mode ? cp_change : cp_fall;
  assign events[`IPC_SRC_STIM] = raw_bits[`IPC_SRC_STIM] & ~raw_prev[`IPC_SRC_STIM];
  assign events[`IPC_SRC_MUTE] = raw_bits[`IPC_SRC_MUTE] & ~raw_prev[`IPC_SRC_MUTE];
  assign events[`IPC_SRC_SD] = raw_bits[`IPC_SRC_SD] & ~raw_prev[`IPC_SRC_SD];

  ////////////////////////////////////////////////////////////////////////
  // sticky status

  wire [NS-1:0] any_mask = mask_a | mask_b | mask_c;
  wire [NS-1:0] unmasked_ok = {2'h0, keep_masked_flags, 2'h0};
  wire [NS-1:0] set_bits = events & (any_mask | unmasked_ok);
  wire clr_wr = reg_wr_i && (reg_addr_i == `IPC_ADDR_CLEAR);
  // write strobe only; nothing is stored, so the clear returns to zero
  wire [NS-1:0] clr_bits = clr_wr ? reg_wdata_i[NS-1:0] : {NS{1'b0}};
  // set wins over a clear in the same cycle
  wire [NS-1:0] next_latched = (latched & ~clr_bits) | set_bits;

  wire [NS-1:0] masked_a = latched & mask_a;
  wire [NS-1:0] masked_b = latched & mask_b;
  wire [NS-1:0] masked_c = latched & mask_c;
  wire pin_a_state = |masked_a;
  wire pin_b_state = |masked_b;
  wire pin_c_state = |masked_c;

  ////////////////////////////////////////////////////////////////////////
  // pulse timing for pins a and b

  wire [2*NS-1:0] masked_ab = {masked_b, masked_a};
  wire [3:0] len_ab = {pin_b_pulse_len, pin_a_pulse_len};
  wire [1:0] state_ab = {pin_b_state, pin_a_state};
  wire [2*NS-1:0] raw_masked_ab = {raw_bits & mask_b, raw_bits & mask_a};
  wire [1:0] raw_out_ab = {pin_b_raw_out, pin_a_raw_out};
  reg [2*NS-1:0] masked_prev;
  wire [1:0] active_ab;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pulse
      reg [6:0] count;
      wire [NS-1:0] cur = masked_ab[g*NS +: NS];
      wire [NS-1:0] prev = masked_prev[g*NS +: NS];
      wire [1:0] code = len_ab[g*2 +: 2];
      wire start = |(cur & ~prev);
      wire [6:0] next_count = start ? pulse_periods(code) :
                              (count != 7'h00) ? count - 7'h01 : 7'h00;
      always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          count <= 7'h00;
        end else begin
          count <= next_count;
        end
      end
      assign active_ab[g] = raw_out_ab[g] ? |raw_masked_ab[g*NS +: NS] :
                            (code == `IPC_LEN_HOLD) ? state_ab[g] :
                            (count != 7'h00);
    end
  endgenerate

  wire pin_b_active = active_ab[1] & pin_b_enable;
  wire [1:0] next_drive_a = pin_drive(pin_a_drive_style, active_ab[0],
                                      pad_ctrl[`IPC_PAD_PDN_A]);
  wire [1:0] next_drive_b = pin_drive(pin_b_drive_style, pin_b_active,
                                      pad_ctrl[`IPC_PAD_PDN_B]);
  wire [1:0] next_drive_c = pin_drive(`IPC_STYLE_OPEN_DRAIN, pin_c_state,
                                      pad_ctrl[`IPC_PAD_PDN_C]);

  ////////////////////////////////////////////////////////////////////////
  // read data

  reg [7:0] next_rdata;
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr_i)
      `IPC_ADDR_PAD_CTRL: next_rdata = pad_ctrl;
      `IPC_ADDR_SUMMARY: begin
        next_rdata[`IPC_SUM_RECEIVER] = receiver_summary_flag;
        next_rdata[`IPC_SUM_CEC] = cec_summary_flag;
        next_rdata[`IPC_SUM_PIN_C] = pin_c_state;
        next_rdata[`IPC_SUM_PIN_B] = pin_b_state;
        next_rdata[`IPC_SUM_PIN_A] = pin_a_state;
      end
      `IPC_ADDR_PIN_A_CFG: next_rdata = pin_a_cfg;
      `IPC_ADDR_PIN_B_CFG: next_rdata = pin_b_cfg;
      `IPC_ADDR_RAW: next_rdata[NS-1:0] = raw_bits;
      `IPC_ADDR_LATCHED: next_rdata[NS-1:0] = latched;
      `IPC_ADDR_MASK_B: next_rdata[NS-1:0] = mask_b;
      `IPC_ADDR_MASK_A: next_rdata[NS-1:0] = mask_a;
      `IPC_ADDR_MASK_C: next_rdata[NS-1:0] = mask_c;
      default: next_rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state and outputs

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pad_ctrl <= `IPC_RST_PAD_CTRL;
      pin_a_cfg <= `IPC_RST_PIN_A_CFG;
      pin_b_cfg <= `IPC_RST_PIN_B_CFG;
      mask_a <= `IPC_RST_MASK;
      mask_b <= `IPC_RST_MASK;
      mask_c <= `IPC_RST_MASK;
      latched <= {NS{1'b0}};
      raw_prev <= {NS{1'b0}};
      masked_prev <= {2*NS{1'b0}};
      cp_locked_prev <= 1'b0;
      cec_summary_flag <= 1'b0;
      receiver_summary_flag <= 1'b0;
      reg_rdata_o <= 8'h00;
      irq_pin_a_o <= 1'b0;
      irq_pin_a_oe_n_o <= 1'b1;
      irq_pin_b_o <= 1'b0;
      irq_pin_b_oe_n_o <= 1'b1;
      irq_pin_c_o <= 1'b0;
      irq_pin_c_oe_n_o <= 1'b1;
    end else begin
      if (reg_wr_i) begin
        case (reg_addr_i)
          `IPC_ADDR_PAD_CTRL: pad_ctrl <= reg_wdata_i;
          `IPC_ADDR_PIN_A_CFG: pin_a_cfg <= reg_wdata_i;
          `IPC_ADDR_PIN_B_CFG: pin_b_cfg <= reg_wdata_i;
          `IPC_ADDR_MASK_B: mask_b <= reg_wdata_i[NS-1:0];
          `IPC_ADDR_MASK_A: mask_a <= reg_wdata_i[NS-1:0];
          `IPC_ADDR_MASK_C: mask_c <= reg_wdata_i[NS-1:0];
          default: begin
          end
        endcase
      end
      latched <= next_latched;
      raw_prev <= raw_bits;
      masked_prev <= {masked_b, masked_a};
      cp_locked_prev <= cp_locked_i;
      cec_summary_flag <= cec_irq_i;
      receiver_summary_flag <= receiver_irq_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
      {irq_pin_a_o, irq_pin_a_oe_n_o} <= next_drive_a;
      {irq_pin_b_o, irq_pin_b_oe_n_o} <= next_drive_b;
      {irq_pin_c_o, irq_pin_c_oe_n_o} <= next_drive_c;
    end
  end

endmodule

// *** verilog/ipc_regs.vh ***
// register offsets, field positions, reset values and pulse counts
// for the interrupt pin controller; included by the controller only
`ifndef IPC_REGS_VH
`define IPC_REGS_VH

// register offsets (8-bit register space)
`define IPC_ADDR_PAD_CTRL 8'h1d
`define IPC_ADDR_SUMMARY 8'h3f
`define IPC_ADDR_PIN_A_CFG 8'h40
`define IPC_ADDR_PIN_B_CFG 8'h41
`define IPC_ADDR_RAW 8'h43
`define IPC_ADDR_LATCHED 8'h44
`define IPC_ADDR_CLEAR 8'h45
`define IPC_ADDR_MASK_B 8'h46
`define IPC_ADDR_MASK_A 8'h47
`define IPC_ADDR_MASK_C 8'h48

// reset values
`define IPC_RST_PAD_CTRL 8'h78
`define IPC_RST_PIN_A_CFG 8'h00
`define IPC_RST_PIN_B_CFG 8'h20
`define IPC_RST_MASK 5'h00

// event source bit positions (raw, latched, clear, masks)
`define IPC_SRC_LOCK 4
`define IPC_SRC_UNLOCK 3
`define IPC_SRC_MUTE 2
`define IPC_SRC_STIM 1
`define IPC_SRC_SD 0
`define IPC_NUM_SRC 5

// pad control fields
`define IPC_PAD_PDN_A 7
`define IPC_PAD_PDN_B 6
`define IPC_PAD_PDN_C 5

// summary register fields
`define IPC_SUM_RECEIVER 5
`define IPC_SUM_CEC 4
`define IPC_SUM_PIN_C 2
`define IPC_SUM_PIN_B 1
`define IPC_SUM_PIN_A 0

// pin configuration fields (length, raw out and style shared by both pins)
`define IPC_CFG_LEN_HI 7
`define IPC_CFG_LEN_LO 6
`define IPC_CFG_KEEP 5
`define IPC_CFG_EDGE 5
`define IPC_CFG_RAW_OUT 4
`define IPC_CFG_PIN_B_EN 3
`define IPC_CFG_STIM 2
`define IPC_CFG_STYLE_HI 1
`define IPC_CFG_STYLE_LO 0

// pulse length codes and lengths in crystal periods
`define IPC_LEN_SHORT 2'h0
`define IPC_LEN_MID 2'h1
`define IPC_LEN_LONG 2'h2
`define IPC_LEN_HOLD 2'h3
`define IPC_PERIODS_SHORT 7'h04
`define IPC_PERIODS_MID 7'h10
`define IPC_PERIODS_LONG 7'h40

// drive style codes
`define IPC_STYLE_OPEN_DRAIN 2'h0
`define IPC_STYLE_ACTIVE_LOW 2'h1
`define IPC_STYLE_ACTIVE_HIGH 2'h2
`define IPC_STYLE_OFF 2'h3

`endif
